// ### common/ifm_pkg.sv
// Constants and register map for the input interrupt and frequency block
package ifm_pkg;
	// ==========================================================
	// Sizes
	localparam int NGRP = 4;
	localparam int ADDR_W = 8;
	localparam logic [31:0] CLK_HZ_DEF = 32'd25000000;
	localparam logic [1:0] MAX_NEST = 2'h3;
	localparam logic [5:0] DIV_LAST = 6'h1f;
	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_ALLOW = 8'h08;
	localparam logic [7:0] ADDR_INSTR = 8'h0c;
	localparam logic [7:0] ADDR_EXEC = 8'h10;
	localparam logic [3:0] LABEL_PAGE = 4'h2;
	localparam logic [3:0] FREQ_PAGE = 4'h3;
	// ==========================================================
	// Field layout
	localparam int RUN_BIT = 0;
	localparam int MODE_STRIDE = 8;
	localparam int EDGE_LSB = 4;
	localparam int OP_LSB = 8;
	localparam int TIMER_BIT = 4;
	localparam logic [4:0] ALLOW_ALL = 5'h1f;
	localparam logic [4:0] ALLOW_RST = 5'h00;
	// ==========================================================
	// Group functions
	localparam logic [2:0] FN_PLAIN = 3'h0;
	localparam logic [2:0] FN_HSC = 3'h1;
	localparam logic [2:0] FN_CATCH = 3'h2;
	localparam logic [2:0] FN_IRQ = 3'h3;
	localparam logic [2:0] FN_FREQ = 3'h4;
	// ==========================================================
	// Instruction opcodes
	localparam logic [2:0] OP_DISABLE = 3'h1;
	localparam logic [2:0] OP_ENABLE = 3'h2;
	localparam logic [2:0] OP_CALL = 3'h3;
	localparam logic [2:0] OP_RETURN = 3'h4;
	localparam logic [2:0] OP_SCAN = 3'h5;
endpackage

// ### test/ifm_field_model.sv
// Field input model driving the four input group pins
`timescale 1ns/10ps
module ifm_field_model (
	input wire logic pclk, // System clock
	input wire logic [3:0] lvl, // Static levels per group
	input wire logic [15:0] half, // Half period of wave, 0 stops it
	output logic [3:0] grp_in // Pins to the block
);
	logic osc = 1'b0;
	logic [15:0] cnt = 16'h0000;
	// ==========================================================
	// Square wave on group four, slow next to any routine
	always @(posedge pclk) begin
		if (half == 16'h0000) begin
			cnt <= 16'h0000;
			osc <= 1'b0;
		end else if (cnt == half - 16'h0001) begin
			cnt <= 16'h0000;
			osc <= ~osc;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
	// Static levels with the wave folded onto group four
	assign grp_in = lvl ^ {1'b0, osc, 2'b00};
endmodule

// ### test/testbench.sv
// Self-checking bench for the interrupt and frequency block
`timescale 1ns/10ps
module testbench;
	import ifm_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq_active, exec_error, err_seen;
	logic [1:0] irq_source;
	logic [15:0] irq_label;
	logic [15:0] half = 16'h0000;
	logic [3:0] lvl = 4'h0;
	logic [3:0] grp_in;
	int err_total = 0;
	int n_tests = 0;
	// ==========================================================
	// Clock, block and field model
	always #20 pclk = ~pclk;
	ifm_top i_ifm_top (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .grp_in(grp_in), .irq_active(irq_active),
		.irq_source(irq_source), .irq_label(irq_label),
		.exec_error(exec_error));
	ifm_field_model i_ifm_field_model (.pclk(pclk), .lvl(lvl),
		.half(half), .grp_in(grp_in));
	// ==========================================================
	// Compare, verdict and bus tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task final_report();
		$display("mismatches %0d, checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One APB transfer; read data and error land in rd, err_seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(32'(n), 32'h1);
	endtask
	// Wait for a routine to start, then compare its source and label
	task wait_irq(input logic [1:0] src, input logic [15:0] lab);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (irq_active !== 1'b1 && n < 20);
		check({29'h0, irq_active, irq_source}, {29'h0, 1'b1, src});
		check({16'h0, irq_label}, {16'h0, lab});
	endtask
	// ==========================================================
	// Scenarios
	task s_regs();
		apb(1'b0, ADDR_ALLOW, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_ALLOW, 32'h0);
		check(rd, 32'h1f);
		apb(1'b0, 8'h44, 32'h0);
		check({31'h0, err_seen}, 32'h1);
		apb(1'b1, 8'h30, 32'h1234);
		apb(1'b0, 8'h30, 32'h0);
		check(rd, 32'h0);
	endtask
	task s_order();
		apb(1'b1, 8'h20, 32'h11);
		apb(1'b1, 8'h24, 32'h22);
		apb(1'b1, 8'h2c, 32'h55);
		apb(1'b0, 8'h24, 32'h0);
		check(rd, 32'h22);
		apb(1'b1, ADDR_MODE, 32'h23041313);
		lvl <= 4'b0011;
		wait_irq(2'h0, 16'h0011);
		apb(1'b1, ADDR_INSTR, 32'h400);
		wait_irq(2'h1, 16'h0022);
		repeat (4) apb(1'b1, ADDR_INSTR, 32'h300);
		@(posedge pclk);
		check({31'h0, exec_error}, 32'h1);
		repeat (4) apb(1'b1, ADDR_INSTR, 32'h400);
		repeat (3) @(posedge pclk);
		check({31'h0, irq_active}, 32'h0);
	endtask
	task s_edge();
		lvl[3] <= 1'b1;
		repeat (10) @(posedge pclk);
		check({31'h0, irq_active}, 32'h0);
		lvl[3] <= 1'b0;
		wait_irq(2'h3, 16'h0055);
		apb(1'b1, ADDR_INSTR, 32'h400);
		apb(1'b1, ADDR_MODE, 32'h33041313);
		lvl[3] <= 1'b1;
		wait_irq(2'h3, 16'h0055);
		apb(1'b1, ADDR_INSTR, 32'h400);
		lvl[3] <= 1'b0;
		wait_irq(2'h3, 16'h0055);
		apb(1'b1, ADDR_INSTR, 32'h400);
	endtask
	task s_mask();
		apb(1'b1, ADDR_INSTR, 32'h101);
		apb(1'b0, ADDR_ALLOW, 32'h0);
		check(rd, 32'h1e);
		lvl[0] <= 1'b0;
		repeat (6) @(posedge pclk);
		lvl[0] <= 1'b1;
		repeat (10) @(posedge pclk);
		check({31'h0, irq_active}, 32'h0);
		apb(1'b1, ADDR_INSTR, 32'h201);
		repeat (10) @(posedge pclk);
		check({31'h0, irq_active}, 32'h0);
	endtask
	task s_freq();
		half <= 16'd1250;
		repeat (6000) @(posedge pclk);
		apb(1'b1, ADDR_INSTR, 32'h500);
		repeat (40) @(posedge pclk);
		apb(1'b0, 8'h38, 32'h0);
		check(rd, CLK_HZ_DEF / 32'd2500);
		apb(1'b0, 8'h30, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, 8'h38, 32'h0);
		check(rd, 32'h0);
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_order();
		s_edge();
		s_mask();
		s_freq();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		check(32'h0, 32'h1);
		final_report();
	end
endmodule

// ### verilog/ifm_top.sv
// Interrupt input and frequency meter logic for input groups two to five
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module ifm_top #(
	parameter logic [31:0] CLK_HZ = ifm_pkg::CLK_HZ_DEF
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes state
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [ifm_pkg::ADDR_W-1:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [ifm_pkg::NGRP-1:0] grp_in, // Field inputs 2..5
	output logic irq_active, // Main program suspended
	output logic [1:0] irq_source, // Group being served
	output logic [15:0] irq_label, // Subroutine label to run
	output logic exec_error // Nesting overflow
);
	import ifm_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [NGRP-1:0] s1;
		logic [NGRP-1:0] s2;
		logic [NGRP-1:0] s3;
		logic run;
		logic [NGRP-1:0][2:0] fn;
		logic [NGRP-1:0][1:0] edg;
		logic [4:0] allow;
		logic [NGRP-1:0] pend;
		logic act;
		logic [1:0] src;
		logic [1:0] depth;
		logic err;
		logic [15:0] cur_lbl;
		logic [NGRP-1:0][15:0] lbl;
		logic [NGRP-1:0][31:0] cnt;
		logic [NGRP-1:0][31:0] per;
		logic [NGRP-1:0] armed;
		logic [NGRP-1:0] fresh;
		logic [NGRP-1:0] busy;
		logic [NGRP-1:0][5:0] step;
		logic [NGRP-1:0][32:0] rem;
		logic [NGRP-1:0][31:0] quo;
		logic [NGRP-1:0][31:0] dvsr;
		logic [NGRP-1:0][31:0] freq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ifm_state_t;

	ifm_state_t r;
	ifm_state_t n;

	logic [NGRP-1:0] rise;
	logic [NGRP-1:0] fall;
	logic [NGRP-1:0] irq_ev;
	logic [NGRP-1:0] freq_ev;
	logic [31:0] mode_rd;
	logic setup;
	logic wr;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_instr;
	logic wr_lbl;
	logic [2:0] op;
	logic op_di;
	logic op_ei;
	logic op_call;
	logic op_ret;
	logic scan;
	logic hit;
	logic [31:0] rd_val;

	// ==========================================================
	// Edge detection per group
	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : g_grp
			// Edges from second and third stage only
			assign rise[g] = r.s2[g] & ~r.s3[g];
			assign fall[g] = ~r.s2[g] & r.s3[g];
			// Selected edge polarity
			assign irq_ev[g] = r.run && (r.fn[g] == FN_IRQ) &&
				((r.edg[g][0] & rise[g]) | (r.edg[g][1] & fall[g]));
			// Only groups 2..5 exist here
			assign freq_ev[g] = (r.fn[g] == FN_FREQ) & rise[g];
			assign mode_rd[g*MODE_STRIDE +: MODE_STRIDE] =
				{2'h0, r.edg[g], 1'h0, r.fn[g]};
		end
	endgenerate

	// ==========================================================
	// Bus strobes and instruction decode
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & r.pready;
	assign wr_ctrl = wr && (paddr == ADDR_CTRL);
	assign wr_mode = wr && (paddr == ADDR_MODE);
	assign wr_instr = wr && (paddr == ADDR_INSTR);
	assign wr_lbl = wr && (paddr[7:4] == LABEL_PAGE) &&
		(paddr[1:0] == 2'h0);
	assign op = pwdata[OP_LSB +: 3];
	assign op_di = wr_instr && (op == OP_DISABLE);
	assign op_ei = wr_instr && (op == OP_ENABLE);
	assign op_call = wr_instr && (op == OP_CALL);
	assign op_ret = wr_instr && (op == OP_RETURN);
	assign scan = wr_instr && (op == OP_SCAN);

	// Read mux and address check
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0;
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else if (paddr == ADDR_CTRL) begin
			rd_val = {31'h0, r.run};
		end else if (paddr == ADDR_MODE) begin
			rd_val = mode_rd;
		end else if (paddr == ADDR_ALLOW) begin
			rd_val = {27'h0, r.allow};
		end else if (paddr == ADDR_INSTR) begin
			rd_val = 32'h0;
		end else if (paddr == ADDR_EXEC) begin
			rd_val = {r.cur_lbl, 10'h0, r.err, r.depth, r.src, r.act};
		end else if (paddr[7:4] == LABEL_PAGE) begin
			rd_val = {16'h0, r.lbl[paddr[3:2]]};
		end else if (paddr[7:4] == FREQ_PAGE) begin
			rd_val = r.freq[paddr[3:2]];
		end else begin
			hit = 1'b0;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic [32:0] t;
		logic [NGRP-1:0] clr;
		logic found;
		t = 33'h0;
		clr = '0;
		found = 1'b0;
		n = r;
		// Synchroniser chain
		n.s1 = grp_in;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// APB answer registered in setup cycle
		n.pready = setup;
		n.pslverr = setup & ~hit;
		n.prdata = setup ? rd_val : 32'h0;
		// Control and configuration writes
		if (wr_ctrl) begin
			n.run = pwdata[RUN_BIT];
			if (pwdata[RUN_BIT] && !r.run) begin
				n.allow = ALLOW_ALL;
				n.err = 1'b0;
			end
		end
		if (wr_mode) begin
			for (int i = 0; i < NGRP; i++) begin
				// One function code per group
				n.fn[i] = pwdata[i*MODE_STRIDE +: 3];
				n.edg[i] = pwdata[i*MODE_STRIDE+EDGE_LSB +: 2];
			end
		end
		if (wr_lbl) begin
			n.lbl[paddr[3:2]] = pwdata[15:0];
		end
		// Per-source disable and enable
		if (op_di) begin
			n.allow = r.allow & ~pwdata[TIMER_BIT:0];
		end
		if (op_ei) begin
			n.allow = r.allow | pwdata[TIMER_BIT:0];
		end
		// Nested calls inside a routine
		if (op_call && r.act) begin
			if (r.depth == MAX_NEST) begin
				n.err = 1'b1;
			end else begin
				n.depth = r.depth + 2'h1;
			end
		end
		// Return ends a call or the routine itself
		if (op_ret && r.act) begin
			if (r.depth != 2'h0) begin
				n.depth = r.depth - 2'h1;
			end else begin
				n.act = 1'b0;
			end
		end
		// Start next routine only when idle
		if (r.run && !r.act) begin
			for (int i = 0; i < NGRP; i++) begin
				// Lowest group wins
				if (r.pend[i] && !found) begin
					found = 1'b1;
					clr[i] = 1'b1;
					n.act = 1'b1;
					n.src = i[1:0];
					n.cur_lbl = r.lbl[i];
					n.depth = 2'h0;
				end
			end
		end
		// Disabled sources drop edges; set beats clear
		n.pend = (r.pend & ~clr) | (irq_ev & r.allow[NGRP-1:0]);
		if (!r.run) begin
			n.pend = '0;
			n.act = 1'b0;
			n.depth = 2'h0;
		end
		// Frequency meter per group
		for (int i = 0; i < NGRP; i++) begin
			if (!r.run || r.fn[i] != FN_FREQ) begin
				// Idle until configured and running
				n.cnt[i] = 32'h0;
				n.armed[i] = 1'b0;
				n.fresh[i] = 1'b0;
				n.busy[i] = 1'b0;
				n.freq[i] = 32'h0;
			end else begin
				// Divide at scan end
				if (scan && r.fresh[i] && !r.busy[i]) begin
					n.busy[i] = 1'b1;
					n.step[i] = 6'h0;
					n.rem[i] = 33'h0;
					n.quo[i] = CLK_HZ;
					n.dvsr[i] = r.per[i];
					n.fresh[i] = 1'b0;
				end else if (r.busy[i]) begin
					// Restoring divide truncates
					t = {r.rem[i][31:0], r.quo[i][31]};
					if (t >= {1'b0, r.dvsr[i]}) begin
						n.rem[i] = t - {1'b0, r.dvsr[i]};
						n.quo[i] = {r.quo[i][30:0], 1'b1};
					end else begin
						n.rem[i] = t;
						n.quo[i] = {r.quo[i][30:0], 1'b0};
					end
					n.step[i] = r.step[i] + 6'h1;
					if (r.step[i] == DIV_LAST) begin
						n.busy[i] = 1'b0;
						n.freq[i] = n.quo[i];
					end
				end
				// Period in clock cycles between rising edges
				if (freq_ev[i]) begin
					n.per[i] = r.cnt[i] + 32'h1;
					n.cnt[i] = 32'h0;
					n.armed[i] = 1'b1;
					n.fresh[i] = r.armed[i] | n.fresh[i];
				end else if (r.cnt[i] != 32'hffffffff) begin
					n.cnt[i] = r.cnt[i] + 32'h1;
				end
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq_active = r.act;
	assign irq_source = r.src;
	assign irq_label = r.cur_lbl;
	assign exec_error = r.err;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_full_call;
		ce && r.run && op_call && r.act && r.depth == MAX_NEST;
	endsequence

	sequence s_idle_grp0;
		ce && r.run && !r.act && r.pend[0] && !wr_ctrl;
	endsequence

	a_run_allows_all: assert property (
		ce && wr_ctrl && pwdata[RUN_BIT] && !r.run |=>
		r.allow == ALLOW_ALL)
		else $error("run entry did not allow all sources");

	a_prio_group0: assert property (
		s_idle_grp0 |=> r.act && r.src == 2'h0)
		else $error("group two not served first");

	a_label_taken: assert property (
		s_idle_grp0 and (!wr_lbl) |=> irq_label == $past(r.lbl[0]))
		else $error("wrong jump label");

	a_single_routine: assert property (
		ce && r.run && r.act && !op_ret && !wr_ctrl |=>
		r.act && $stable(r.src))
		else $error("routine replaced before return");

	// A source that fires mid-routine stays queued until served
	a_pend_waits: assert property (
		ce && r.run && r.act && r.pend[1] && !wr_ctrl |=> r.pend[1])
		else $error("pending source lost during routine");

	a_nest_error: assert property (
		s_full_call |=> exec_error && r.depth == MAX_NEST)
		else $error("fourth nested call not flagged");

	a_disable_flag: assert property (
		ce && op_di && pwdata[0] |=> !r.allow[0])
		else $error("disable did not clear allowed flag");

	a_drop_disabled: assert property (
		ce && !r.allow[0] && !r.pend[0] && r.run |=> !r.pend[0])
		else $error("edge queued on disabled source");

	a_edge_single: assert property (
		ce && rise[0] ##1 ce |-> !rise[0])
		else $error("edge pulse longer than one cycle");

	a_freq_stopped: assert property (
		ce && !r.run |=> r.cnt[2] == 32'h0 && !r.busy[2])
		else $error("meter active while stopped");

	// Divider finishes after its last step and posts a result
	a_div_done: assert property (
		ce && r.run && r.fn[2] == FN_FREQ && r.busy[2] &&
		r.step[2] == DIV_LAST |=> !r.busy[2])
		else $error("divider did not finish on last step");
endmodule
